// [design/aor_defs.svh]
// Register offsets, field positions and reset values of the output block
`ifndef AOR_DEFS_SVH
`define AOR_DEFS_SVH
`define AOR_A_CTRL1     8'h20
`define AOR_A_FILT      8'h21
`define AOR_A_PIN1      8'h22
`define AOR_A_FMT       8'h23
`define AOR_A_CTRL5     8'h24
`define AOR_A_PIN2      8'h25
`define AOR_A_REF       8'h26
`define AOR_A_STAT      8'h27
`define AOR_A_OUTXL     8'h28
`define AOR_A_CFG       8'h30
`define AOR_A_SRC       8'h31
`define AOR_PAIR_STRIDE 8'h02
`define AOR_REG_RST     8'h00
`define AOR_ODR_OFF     4'h0
`define AOR_ODR_MSB     7
`define AOR_ODR_LSB     4
`define AOR_AXEN_MSB    2
`define AOR_AXEN_LSB    0
`define AOR_HPM_MSB     7
`define AOR_HPM_LSB     6
`define AOR_FILTER_CUTOFF_CODE_MSB    5
`define AOR_FILTER_CUTOFF_CODE_LSB    4
`define AOR_B_FDS       3
`define AOR_B_FILTER_ON_IRQ_GEN2     1
`define AOR_B_FILTER_ON_IRQ_GEN1     0
`define AOR_HP_SHIFT    3'h4
`define AOR_B_P1_TAP    7
`define AOR_B_P1_GEN1   6
`define AOR_B_P1_DRDY   4
`define AOR_B_P1_WTM    2
`define AOR_B_P1_QOVR   1
`define AOR_B_P2_TAP    7
`define AOR_B_P2_GEN1   6
`define AOR_B_P2_BOOT   4
`define AOR_B_POL       1
`define AOR_B_BDU       7
`define AOR_B_BLE       6
`define AOR_B_LATCH     3
`define AOR_B_AOI       7
`define AOR_B_SIXD      6
`define AOR_CFG_EN_MSB  5
`define AOR_CFG_EN_LSB  0
`define AOR_B_IA        6
`define AOR_B_STAT_OR   7
`define AOR_B_STAT_DA   3
`define AOR_HB_MSB      15
`define AOR_HB_LSB      8
`define AOR_LB_MSB      7
`define AOR_LB_LSB      0
`define AOR_BUF_DEPTH   2
`endif

// [design/aor_pkg.sv]
// Types shared by the acceleration output block
package aor_pkg;
	localparam int AOR_WORD_W = 16;
	localparam int AOR_SMP_W  = 48;
	typedef logic [7:0]         aor_byte_t;
	typedef logic signed [15:0] aor_word_t;
	typedef enum logic [1:0] {
		AOR_HP_NORM_RST = 2'h0,
		AOR_HP_REFER    = 2'h1,
		AOR_HP_NORM     = 2'h2,
		AOR_HP_AUTO     = 2'h3
	} aor_hpm_t;
	typedef enum logic [1:0] {
		AOR_CMB_OR   = 2'h0,
		AOR_CMB_MOVE = 2'h1,
		AOR_CMB_AND  = 2'h2,
		AOR_CMB_POSN = 2'h3
	} aor_cmb_t;
	typedef struct packed {
		logic                 sclk_s1, sclk_s2, sclk_s3, sval_s1, sval_s2;
		logic [47:0]          sdat_s1, sdat_s2;
		aor_byte_t            ctrl1, filt, pin1, fmt, ctrl5, pin2, ref_v, cfg, src, rdata;
		aor_word_t [2:0]      raw, dc, live, shown, irqd;
		logic [2:0]           lock, seen_lo, seen_hi, pend;
		logic                 da, ovr, cond_prev, irq_pin_one, irq_pin_two;
		logic [5:0]           hits_prev;
	} aor_state_t;
endpackage

// [design/aor_pair_buf.sv]
// Two-entry sample buffer with valid/ready on both sides
`timescale 1ns/1ps
`include "aor_defs.svh"
module aor_pair_buf
	import aor_pkg::*;
#(
	parameter int W = AOR_SMP_W,
	parameter int D = `AOR_BUF_DEPTH
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	// Filling side
	input  wire logic         in_valid_in,
	input  wire logic [W-1:0] in_data_in,
	output logic              in_ready_out,
	// Draining side
	output logic              out_valid_out,
	output logic [W-1:0]      out_data_out,
	input  wire logic         out_ready_in
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wr;
		logic [AW-1:0]       rd;
		logic [CW-1:0]       cnt;
	} aor_buf_st_t;
	aor_buf_st_t s, n;
	logic        push, take;

	assign in_ready_out  = s.cnt != CW'(D);
	assign out_valid_out = s.cnt != '0;
	assign out_data_out  = s.mem[s.rd];
	assign push          = in_valid_in & in_ready_out;
	assign take          = out_valid_out & out_ready_in;

	always_comb begin
		n = s;
		if (push) begin
			n.mem[s.wr] = in_data_in;
			n.wr = (s.wr == AW'(D - 1)) ? '0 : AW'(s.wr + AW'(1));
		end
		if (take) begin
			n.rd = (s.rd == AW'(D - 1)) ? '0 : AW'(s.rd + AW'(1));
		end
		n.cnt = CW'(s.cnt + CW'(push) - CW'(take));
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule

// [design/aor_sensor_out.sv]
// Sample registers, status flags, high-pass filter and interrupt pin routing
`timescale 1ns/1ps
`include "aor_defs.svh"
// Functional notes
// - New-data flag bit 3 on complete set
// - Overrun flag bit 7 when unread data overwritten
// - Overrun clears after full read, no new sample
// - Data-ready routed to pin one when enabled
// - Polarity bit zero high, one low
// - Data-ready rises when new set ready
// - Data-ready drops after all enabled high bytes
// - Block update freezes pair until both read
// - Sample is low byte then high byte
// - Byte order bit swaps low and high
// - Filter selectable separately for output and interrupt
// - Two-bit filter mode field decoding
// - Cut-off code scales filter corner with rate
// - Reference read resets filter in mode 00, not in mode 10
// - Reference mode subtracts reference register value
// - Autoreset on interrupt event, read also resets
// - Pin one sources each gated by enable
// - AND/OR and six-direction select combination
// - Event asserts interrupt, records source axes
// - Disabled axis samples zero; reports zero when unfiltered
// - Power-down freezes output registers
// - Latched interrupt held until source read
module aor_sensor_out
	import aor_pkg::*;
(
	// Clock and reset
	input  wire logic        REF_CLK_IN,
	input  wire logic        RSTN_IN,
	// Register port
	input  wire logic [7:0]  REG_ADDR_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic [7:0]  REG_WDATA_IN,
	input  wire logic        REG_RD_IN,
	output logic [7:0]       REG_RDATA_OUT,
	// Sample link
	input  wire logic        SMP_CLK_IN,
	input  wire logic        SMP_VALID_IN,
	input  wire logic [47:0] SMP_DATA_IN,
	output logic             SMP_READY_OUT,
	// Interrupt sources
	input  wire logic [5:0]  GEN1_AXIS_IN,
	input  wire logic        TAP_IN,
	input  wire logic        WTM_IN,
	input  wire logic        QOVR_IN,
	input  wire logic        BOOT_IN,
	// Interrupt data path and pins
	output logic [47:0]      GEN1_DATA_OUT,
	output logic             IRQ_PIN_ONE_OUT,
	output logic             IRQ_PIN_TWO_OUT
);
	aor_state_t  s, n;
	logic        edge_seen, drain_ok, pop, buf_valid, buf_ready, cond, flt_rst, rd_src, block_update_enable;
	logic [47:0] buf_data;
	logic [5:0]  hits, cfg_en;
	logic [2:0]  axen;
	aor_hpm_t    hpm;
	aor_cmb_t    cmb;

	function automatic aor_word_t hp_step(input aor_word_t x, input aor_word_t dc,
			input logic [1:0] code);
		logic signed [16:0] diff;
		logic signed [16:0] sum;
		diff = $signed({x[15], x}) - $signed({dc[15], dc});
		sum  = $signed({dc[15], dc}) + (diff >>> ({1'b0, code} + `AOR_HP_SHIFT));
		return sum[15:0];
	endfunction

	function automatic aor_byte_t pair_addr(input logic [1:0] ax, input logic hi);
		return aor_byte_t'(`AOR_A_OUTXL + ax * `AOR_PAIR_STRIDE + {7'h00, hi});
	endfunction

	function automatic aor_byte_t pick_byte(input aor_word_t w, input logic slot_hi,
			input logic swap);
		return (slot_hi ^ swap) ? w[`AOR_HB_MSB:`AOR_HB_LSB] : w[`AOR_LB_MSB:`AOR_LB_LSB];
	endfunction

	// Only the rising edge is used; the link clock is far slower than ours
	assign edge_seen = s.sclk_s2 & ~s.sclk_s3;
	assign drain_ok  = s.ctrl1[`AOR_ODR_MSB:`AOR_ODR_LSB] != `AOR_ODR_OFF;
	assign pop       = buf_valid & drain_ok;
	assign axen      = s.ctrl1[`AOR_AXEN_MSB:`AOR_AXEN_LSB];
	assign hpm       = aor_hpm_t'(s.filt[`AOR_HPM_MSB:`AOR_HPM_LSB]);
	assign cmb       = aor_cmb_t'({s.cfg[`AOR_B_AOI], s.cfg[`AOR_B_SIXD]});
	assign cfg_en    = s.cfg[`AOR_CFG_EN_MSB:`AOR_CFG_EN_LSB];
	assign hits      = GEN1_AXIS_IN & cfg_en;
	assign block_update_enable       = s.fmt[`AOR_B_BDU];
	assign rd_src    = REG_RD_IN && (REG_ADDR_IN == `AOR_A_SRC);

	always_comb begin
		case (cmb)
			AOR_CMB_OR:   cond = |hits;
			AOR_CMB_MOVE: cond = (|hits) && (hits != s.hits_prev);
			AOR_CMB_AND:  cond = (|cfg_en) && (hits == cfg_en);
			AOR_CMB_POSN: cond = $onehot(hits);
			default:      cond = 1'b0;
		endcase
	end

	// Mode 10 ignores the reset read; 00 and autoreset honour it
	assign flt_rst = (REG_RD_IN && (REG_ADDR_IN == `AOR_A_REF) &&
		(hpm == AOR_HP_NORM_RST || hpm == AOR_HP_AUTO)) ||
		(hpm == AOR_HP_AUTO && cond && !s.cond_prev);

	aor_pair_buf #(
		.W (AOR_SMP_W),
		.D (`AOR_BUF_DEPTH)
	) u_buf (
		.clk_in        (REF_CLK_IN),
		.rstn_in       (RSTN_IN),
		.in_valid_in   (edge_seen & s.sval_s2),
		.in_data_in    (s.sdat_s2),
		.in_ready_out  (buf_ready),
		.out_valid_out (buf_valid),
		.out_data_out  (buf_data),
		.out_ready_in  (drain_ok)
	);

	always_comb begin
		aor_word_t x_v;
		aor_word_t f_v;
		x_v = '0;
		f_v = '0;
		n = s;
		n.sclk_s1 = SMP_CLK_IN;
		n.sclk_s2 = s.sclk_s1;
		n.sclk_s3 = s.sclk_s2;
		n.sval_s1 = SMP_VALID_IN;
		n.sval_s2 = s.sval_s1;
		n.sdat_s1 = SMP_DATA_IN;
		n.sdat_s2 = s.sdat_s1;
		n.cond_prev = cond;
		n.hits_prev = hits;
		if (REG_WR_IN) begin
			case (REG_ADDR_IN)
				`AOR_A_CTRL1: n.ctrl1 = REG_WDATA_IN;
				`AOR_A_FILT:  n.filt  = REG_WDATA_IN;
				`AOR_A_PIN1:  n.pin1  = REG_WDATA_IN;
				`AOR_A_FMT:   n.fmt   = REG_WDATA_IN;
				`AOR_A_CTRL5: n.ctrl5 = REG_WDATA_IN;
				`AOR_A_PIN2:  n.pin2  = REG_WDATA_IN;
				`AOR_A_REF:   n.ref_v = REG_WDATA_IN;
				`AOR_A_CFG:   n.cfg   = REG_WDATA_IN;
				default: ;
			endcase
		end
		if (REG_RD_IN) begin
			n.rdata = `AOR_REG_RST;
			case (REG_ADDR_IN)
				`AOR_A_CTRL1: n.rdata = s.ctrl1;
				`AOR_A_FILT:  n.rdata = s.filt;
				`AOR_A_PIN1:  n.rdata = s.pin1;
				`AOR_A_FMT:   n.rdata = s.fmt;
				`AOR_A_CTRL5: n.rdata = s.ctrl5;
				`AOR_A_PIN2:  n.rdata = s.pin2;
				`AOR_A_REF:   n.rdata = s.ref_v;
				`AOR_A_CFG:   n.rdata = s.cfg;
				`AOR_A_SRC:   n.rdata = s.src;
				`AOR_A_STAT: begin
					n.rdata[`AOR_B_STAT_OR] = s.ovr;
					n.rdata[`AOR_B_STAT_DA] = s.da;
				end
				default: ;
			endcase
			for (int i = 0; i < 3; i++) begin
				if (REG_ADDR_IN == pair_addr(2'(i), 1'b0)) begin
					n.rdata = pick_byte(s.shown[i], 1'b0, s.fmt[`AOR_B_BLE]);
					n.seen_lo[i] = 1'b1;
					n.lock[i] = n.lock[i] | block_update_enable;
				end
				if (REG_ADDR_IN == pair_addr(2'(i), 1'b1)) begin
					n.rdata = pick_byte(s.shown[i], 1'b1, s.fmt[`AOR_B_BLE]);
					n.seen_hi[i] = 1'b1;
					n.lock[i] = n.lock[i] | block_update_enable;
					n.pend[i] = 1'b0;
				end
				if (n.seen_lo[i] && n.seen_hi[i]) begin
					n.seen_lo[i] = 1'b0;
					n.seen_hi[i] = 1'b0;
					n.lock[i] = 1'b0;
				end
			end
		end
		// A new sample wins over a read in the same cycle
		if (pop) begin
			n.da = 1'b1;
			if (s.da) begin
				n.ovr = 1'b1;
			end
			n.pend = axen;
			for (int i = 0; i < 3; i++) begin
				x_v = axen[i] ? buf_data[i*AOR_WORD_W +: AOR_WORD_W] : '0;
				n.raw[i] = x_v;
				if (hpm == AOR_HP_REFER) begin
					f_v = x_v - aor_word_t'({s.ref_v, `AOR_REG_RST});
				end else begin
					f_v = x_v - s.dc[i];
					n.dc[i] = hp_step(x_v, s.dc[i],
						s.filt[`AOR_FILTER_CUTOFF_CODE_MSB:`AOR_FILTER_CUTOFF_CODE_LSB]);
				end
				n.live[i] = s.filt[`AOR_B_FDS] ? f_v : x_v;
				n.irqd[i] = s.filt[`AOR_B_FILTER_ON_IRQ_GEN1] ? f_v : x_v;
			end
		end else if (s.da && n.pend == '0) begin
			n.da = 1'b0;
			n.ovr = 1'b0;
		end
		if (flt_rst) begin
			for (int i = 0; i < 3; i++) begin
				n.dc[i] = n.raw[i];
			end
		end
		for (int i = 0; i < 3; i++) begin
			if (!(block_update_enable && n.lock[i])) begin
				n.shown[i] = n.live[i];
			end
		end
		if (cond) begin
			n.src[`AOR_B_IA] = 1'b1;
			n.src[`AOR_CFG_EN_MSB:`AOR_CFG_EN_LSB] = hits;
		end else if (!s.ctrl5[`AOR_B_LATCH] || rd_src) begin
			n.src[`AOR_B_IA] = 1'b0;
		end
		n.irq_pin_one = n.pin2[`AOR_B_POL] ^ |{
			n.pin1[`AOR_B_P1_TAP] & TAP_IN,
			n.pin1[`AOR_B_P1_GEN1] & n.src[`AOR_B_IA],
			n.pin1[`AOR_B_P1_DRDY] & n.da,
			n.pin1[`AOR_B_P1_WTM] & WTM_IN,
			n.pin1[`AOR_B_P1_QOVR] & QOVR_IN};
		n.irq_pin_two = n.pin2[`AOR_B_POL] ^ |{
			n.pin2[`AOR_B_P2_TAP] & TAP_IN,
			n.pin2[`AOR_B_P2_GEN1] & n.src[`AOR_B_IA],
			n.pin2[`AOR_B_P2_BOOT] & BOOT_IN};
	end

	always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign REG_RDATA_OUT = s.rdata;
	assign SMP_READY_OUT = buf_ready;
	assign GEN1_DATA_OUT = s.irqd;
	assign IRQ_PIN_ONE_OUT      = s.irq_pin_one;
	assign IRQ_PIN_TWO_OUT      = s.irq_pin_two;

	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!RSTN_IN);

	property p_da_set;
		pop |=> s.da;
	endproperty
	a_da_set: assert property (p_da_set) else $error("new-data flag not set");

	property p_ovr_set;
		(pop && s.da) |=> s.ovr;
	endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged");

	property p_ovr_clr;
		$fell(s.da) |-> !s.ovr && !$past(pop);
	endproperty
	a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");

	property p_pin1_drdy;
		(s.da && s.pin1[`AOR_B_P1_DRDY]) |-> (IRQ_PIN_ONE_OUT == !s.pin2[`AOR_B_POL]);
	endproperty
	a_pin1_drdy: assert property (p_pin1_drdy) else $error("pin one wrong");

	property p_da_fall;
		$fell(s.da) |-> s.pend == '0;
	endproperty
	a_da_fall: assert property (p_da_fall) else $error("ready dropped early");

	property p_bdu_hold;
		(block_update_enable && s.lock[0] && n.lock[0]) |=> $stable(s.shown[0]);
	endproperty
	a_bdu_hold: assert property (p_bdu_hold) else $error("locked pair moved");

	property p_order;
		(REG_RD_IN && REG_ADDR_IN == `AOR_A_OUTXL)
			|=> REG_RDATA_OUT == ($past(s.fmt[`AOR_B_BLE]) ?
			$past(s.shown[0][`AOR_HB_MSB:`AOR_HB_LSB]) :
			$past(s.shown[0][`AOR_LB_MSB:`AOR_LB_LSB]));
	endproperty
	a_order: assert property (p_order) else $error("byte order wrong");

	property p_flt_rst;
		(flt_rst && !pop) |=> s.dc == $past(s.raw);
	endproperty
	a_flt_rst: assert property (p_flt_rst) else $error("filter not reset");

	property p_axis_off;
		(pop && !axen[1]) |=> s.raw[1] == '0;
	endproperty
	a_axis_off: assert property (p_axis_off) else $error("disabled axis nonzero");

	property p_pdown;
		!drain_ok |-> !pop ##1 $stable(s.shown);
	endproperty
	a_pdown: assert property (p_pdown) else $error("output moved in power-down");

	property p_latch;
		(s.ctrl5[`AOR_B_LATCH] && s.src[`AOR_B_IA] && !rd_src) |=> s.src[`AOR_B_IA];
	endproperty
	a_latch: assert property (p_latch) else $error("latched event lost");
endmodule

// [verification/aor_smp_src.sv]
// Sample link source model that drives one word per link clock period
`timescale 1ns/1ps
module aor_smp_src (
	// Link side
	output logic        smp_clk_out,
	output logic        smp_valid_out,
	output logic [47:0] smp_data_out,
	input  wire logic   smp_ready_in
);
	initial begin
		smp_clk_out = 1'b0;
		smp_valid_out = 1'b0;
		smp_data_out = 48'h0000_0000_0000;
	end
	// Link clock runs only inside a word; released data is inverted so stale bits never look valid
	task automatic send(input logic [47:0] w);
		smp_data_out = w;
		smp_valid_out = 1'b1;
		wait (smp_ready_in === 1'b1);
		#62.5 smp_clk_out = 1'b1;
		#62.5 smp_clk_out = 1'b0;
		smp_valid_out = 1'b0;
		smp_data_out = ~w;
		// Idle gap so a following word never lands in the same time step as this release
		#62.5;
	endtask
endmodule

// [verification/aor_sensor_out_test.sv]
// Self-checking bench for the acceleration output block
`timescale 1ns/1ps
module aor_sensor_out_test;
	import aor_pkg::*;
	logic        clk, rstn, wr, rd, tap, wtm, qovr, boot;
	logic        sclk, svalid, sready, irq_pin_one, irq_pin_two;
	logic [7:0]  addr, wdata, rdata, v;
	logic [5:0]  axis;
	logic [47:0] sdata, gdata;
	int          n_errors, tests_run, cyc;

	aor_sensor_out u_dut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .REG_ADDR_IN(addr),
		.REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
		.SMP_CLK_IN(sclk), .SMP_VALID_IN(svalid), .SMP_DATA_IN(sdata),
		.SMP_READY_OUT(sready), .GEN1_AXIS_IN(axis), .TAP_IN(tap), .WTM_IN(wtm),
		.QOVR_IN(qovr), .BOOT_IN(boot), .GEN1_DATA_OUT(gdata), .IRQ_PIN_ONE_OUT(irq_pin_one),
		.IRQ_PIN_TWO_OUT(irq_pin_two));
	aor_smp_src u_src (.smp_clk_out(sclk), .smp_valid_out(svalid), .smp_data_out(sdata),
		.smp_ready_in(sready));

	always #2 clk = ~clk;

	// Run is about a thousand cycles; the ceiling leaves wide margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish;
		end
	end

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rreg(a, v);
		chk8($sformatf("reg_%h", a), e, v);
	endtask

	// Host order: low then high byte, X then Y then Z
	task automatic rd_all(input logic [47:0] w, input logic sw);
		for (int i = 0; i < 6; i++)
			rchk(8'h28 + 8'(i), w[8*(i ^ int'(sw)) +: 8]);
	endtask

	task automatic wait_da;
		v = 8'h00;
		for (int i = 0; i < 100 && v[3] !== 1'b1; i++)
			rreg(8'h27, v);
	endtask

	task automatic irq(input logic [7:0] p1, input logic [7:0] p2, input logic [3:0] s,
			input logic [5:0] ax, input logic e1, input logic e2);
		wreg(8'h22, p1);
		wreg(8'h25, p2);
		@(posedge clk);
		{tap, wtm, qovr, boot} <= s;
		axis <= ax;
		// Pins are registered: the event shows one edge after it is driven
		@(posedge clk);
		#1 chk1("irq_pin_one", e1, irq_pin_one);
		chk1("irq_pin_two", e2, irq_pin_two);
		@(posedge clk);
		{tap, wtm, qovr, boot} <= 4'h0;
		axis <= 6'h00;
		repeat (2) @(posedge clk);
	endtask

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		tap = 1'b0;
		wtm = 1'b0;
		qovr = 1'b0;
		boot = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		axis = 6'h00;
		n_errors = 0;
		tests_run = 0;
		cyc = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 18; i++)
			rchk(8'h20 + 8'(i), 8'h00);
		wreg(8'h20, 8'h57);
		wreg(8'h22, 8'h10);
		u_src.send(48'hC000_EA20_15E0);
		wait_da;
		chk8("status", 8'h08, v);
		chk1("irq_pin_one", 1'b1, irq_pin_one);
		rd_all(48'hC000_EA20_15E0, 1'b0);
		repeat (2) @(posedge clk);
		#1 chk1("irq_pin_one", 1'b0, irq_pin_one);
		u_src.send(48'h1111_2222_3333);
		u_src.send(48'h4400_5500_6600);
		wait_da;
		chk8("status", 8'h88, v);
		rd_all(48'h4400_5500_6600, 1'b0);
		rchk(8'h27, 8'h00);
		wreg(8'h23, 8'h40);
		u_src.send(48'h0400_15E0_C000);
		wait_da;
		rd_all(48'h0400_15E0_C000, 1'b1);
		wreg(8'h23, 8'h80);
		wreg(8'h20, 8'h51);
		u_src.send(48'h7777_8888_1234);
		wait_da;
		rd_all(48'h0000_0000_1234, 1'b0);
		u_src.send(48'h0000_0000_ABCD);
		wait_da;
		rchk(8'h29, 8'hAB);
		u_src.send(48'h0000_0000_5678);
		wait_da;
		rchk(8'h28, 8'hCD);
		rchk(8'h29, 8'h56);
		rchk(8'h28, 8'h78);
		// Power-down stops the drain, so two words fill the buffer
		wreg(8'h23, 8'h00);
		wreg(8'h20, 8'h01);
		u_src.send(48'h0000_0000_1357);
		u_src.send(48'h0000_0000_2468);
		@(posedge clk);
		#1 chk1("ready", 1'b0, sready);
		rchk(8'h28, 8'h78);
		wreg(8'h20, 8'h51);
		wait_da;
		chk1("ready", 1'b1, sready);
		rchk(8'h28, 8'h68);
		rchk(8'h29, 8'h24);
		wreg(8'h26, 8'h10);
		wreg(8'h21, 8'h48);
		u_src.send(48'h0000_0000_2345);
		wait_da;
		rchk(8'h28, 8'h45);
		rchk(8'h29, 8'h13);
		chk8("gen1_x_hi", 8'h23, gdata[15:8]);
		wreg(8'h21, 8'h08);
		rchk(8'h26, 8'h10);
		u_src.send(48'h0000_0000_2345);
		wait_da;
		rchk(8'h28, 8'h00);
		rchk(8'h29, 8'h00);
		// Autoreset mode, cut-off code 01, filtered output
		wreg(8'h21, 8'hD8);
		u_src.send(48'h0000_0000_3345);
		wait_da;
		rchk(8'h28, 8'h00);
		rchk(8'h29, 8'h10);
		u_src.send(48'h0000_0000_3345);
		wait_da;
		rchk(8'h28, 8'h80);
		rchk(8'h29, 8'h0F);
		wreg(8'h30, 8'h02);
		irq(8'h00, 8'h00, 4'hF, 6'h02, 1'b0, 1'b0);
		irq(8'h80, 8'h00, 4'h8, 6'h00, 1'b1, 1'b0);
		irq(8'h04, 8'h00, 4'h4, 6'h00, 1'b1, 1'b0);
		irq(8'h02, 8'h00, 4'h2, 6'h00, 1'b1, 1'b0);
		irq(8'h40, 8'h00, 4'h0, 6'h02, 1'b1, 1'b0);
		irq(8'h00, 8'h80, 4'h8, 6'h00, 1'b0, 1'b1);
		irq(8'h00, 8'h40, 4'h0, 6'h02, 1'b0, 1'b1);
		irq(8'h00, 8'h10, 4'h1, 6'h00, 1'b0, 1'b1);
		irq(8'h00, 8'h02, 4'h0, 6'h00, 1'b1, 1'b1);
		irq(8'h80, 8'h82, 4'h8, 6'h00, 1'b0, 1'b0);
		wreg(8'h30, 8'h83);
		irq(8'h40, 8'h00, 4'h0, 6'h02, 1'b0, 1'b0);
		irq(8'h40, 8'h00, 4'h0, 6'h03, 1'b1, 1'b0);
		wreg(8'h30, 8'hC3);
		irq(8'h40, 8'h00, 4'h0, 6'h02, 1'b1, 1'b0);
		irq(8'h40, 8'h00, 4'h0, 6'h03, 1'b0, 1'b0);
		wreg(8'h30, 8'h03);
		irq(8'h40, 8'h00, 4'h0, 6'h01, 1'b1, 1'b0);
		// Latched: pin holds after the condition goes until the source is read
		wreg(8'h30, 8'h02);
		wreg(8'h24, 8'h08);
		irq(8'h40, 8'h00, 4'h0, 6'h02, 1'b1, 1'b0);
		#1 chk1("irq_pin_one", 1'b1, irq_pin_one);
		rchk(8'h31, 8'h42);
		repeat (2) @(posedge clk);
		#1 chk1("irq_pin_one", 1'b0, irq_pin_one);
		// Gen1 events above reset the filter to the last raw sample
		u_src.send(48'h0000_0000_3345);
		wait_da;
		rchk(8'h28, 8'h00);
		rchk(8'h29, 8'h00);
		tally_and_finish;
	end
endmodule
